// file: verilog/csi_top.sv
// Card status indicator: rear LEDs and host status codes
// Contract
// R01: Lock LED green while bit-sync loop locked
// R02: Three LEDs show host-assigned card number
// R03: Lit is one; top LED is MSB
// R04: Lower left lock, lower right config
// R05: Bit lock code one locked, zero not
// R06: Frame code two lock, one check, zero
// R07: Subframe code only when subframe sync configured
// R08: Subframe counter readable only when configured
// R09: Time code three, one, zero by flywheel
// R10: Host writes card number; device holds it
`timescale 1ns/10ps
`include "csi_defs.svh"
module csi_top #(
   parameter int SFC_W = 10
) (
   input  wire logic                     i_mclk,
   input  wire logic                     i_rstn,
   input  wire logic                     i_bit_dpll_locked,
   input  wire logic                     i_cfg_done,
   input  wire logic                     i_card_num_we,
   input  wire logic [2:0]               i_card_num,
   input  wire csi_pkg::csi_sync_e       i_frame_sync_state,
   input  wire csi_pkg::csi_sync_e       i_subframe_sync_state,
   input  wire logic                     i_subframe_sync_en,
   input  wire logic [SFC_W-1:0]         i_subframe_count,
   input  wire logic                     i_time_locked,
   input  wire logic                     i_time_flywheel,
   output csi_pkg::csi_card_leds_s       o_card_leds,
   output logic                          o_bit_lock_led,
   output logic                          o_cfg_led,
   output csi_pkg::csi_status_s          o_status,
   output logic [SFC_W-1:0]              o_subframe_counter_value
);
   // Counter width outside 1 to 16 bits is refused at elaboration
   if (SFC_W < 1 || SFC_W > 16) begin : g_bad_sfc_w
      $error("csi_top: SFC_W must be 1 to 16");
   end
   // --------------------------------------------------
   // Lock pin crosses in from the bit synchroniser
   // --------------------------------------------------
   logic lock_lvl;
   csi_pin_sync #(.WIDTH(1)) u_lock_sync (
      .i_mclk  (i_mclk),
      .i_rstn  (i_rstn),
      .i_async (i_bit_dpll_locked),
      .o_level (lock_lvl)
   );
   // Encode a tracking state onto the host code
   function automatic logic [1:0] sync_code(csi_pkg::csi_sync_e s);
      case (s)
         csi_pkg::CSI_LOCK:  sync_code = `CSI_FS_LOCK;
         csi_pkg::CSI_CHECK: sync_code = `CSI_FS_CHECK;
         default:            sync_code = `CSI_FS_SEARCH;
      endcase
   endfunction
   // --------------------------------------------------
   // Next-state logic
   // --------------------------------------------------
   logic [2:0]           card_q, card_d;
   logic                 blk_q, blk_d, cfg_q, cfg_d;
   csi_pkg::csi_status_s st_q, st_d;
   logic [SFC_W-1:0]     sfc_q, sfc_d;
   always_comb begin
      card_d = card_q;
      if (i_card_num_we) begin
         card_d = i_card_num;                               // R10
      end
      blk_d = lock_lvl;                                     // R01
      cfg_d = i_cfg_done;                                   // R04
      st_d  = '0;
      st_d.bit_lock_code = lock_lvl ? `CSI_BIT_LOCKED
                                    : `CSI_BIT_UNLOCKED;    // R05
      st_d.frame_sync_state_code = sync_code(i_frame_sync_state); // R06
      // Unconfigured subframe path reports nothing, flagged invalid
      st_d.sf_valid = i_subframe_sync_en;                   // R07
      if (i_subframe_sync_en) begin
         st_d.subframe_sync_state_code =
            sync_code(i_subframe_sync_state);               // R07
      end
      // Locked without flywheel is not a listed state; report lock
      if (i_time_locked) begin
         st_d.time_reader_state_code = `CSI_TC_LOCK_FLY;    // R09
      end else if (i_time_flywheel) begin
         st_d.time_reader_state_code = `CSI_TC_UNLOCK_FLY;  // R09
      end else begin
         st_d.time_reader_state_code = `CSI_TC_UNLOCK_NOFLY; // R09
      end
      sfc_d = i_subframe_sync_en ? i_subframe_count : '0;   // R08
   end
   // Registers only
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         card_q <= `CSI_CARD_NUM_RST;
         blk_q  <= 1'h0;
         cfg_q  <= 1'h0;
         st_q   <= '0;
         sfc_q  <= '0;
      end else begin
         card_q <= card_d;
         blk_q  <= blk_d;
         cfg_q  <= cfg_d;
         st_q   <= st_d;
         sfc_q  <= sfc_d;
      end
   end
   // --------------------------------------------------
   // Outputs: LED lit for one, bit 2 on the top LED
   // --------------------------------------------------
   assign o_card_leds.card_num_msb_led = card_q[2];         // R02 R03
   assign o_card_leds.card_num_mid_led = card_q[1];         // R03
   assign o_card_leds.card_num_lsb_led = card_q[0];         // R03
   assign o_bit_lock_led           = blk_q;                 // R04
   assign o_cfg_led                = cfg_q;
   assign o_status                 = st_q;
   assign o_subframe_counter_value = sfc_q;
   // --------------------------------------------------
   // Checks
   // --------------------------------------------------
   sequence s_card_write;
      i_card_num_we ##1 1'h1;
   endsequence
   property p_card_hold;
      @(posedge i_mclk) disable iff (!i_rstn)
         !i_card_num_we |=> $stable(o_card_leds);
   endproperty
   a_card_hold: assert property (p_card_hold) // R10
      else $error("card number changed without write");
   property p_card_show;
      @(posedge i_mclk) disable iff (!i_rstn)
         i_card_num_we |=> o_card_leds == $past(i_card_num);
   endproperty
   a_card_show: assert property (p_card_show) // R02
      else $error("card LEDs do not show written number");
   property p_msb_top;
      @(posedge i_mclk) disable iff (!i_rstn)
         s_card_write |-> o_card_leds.card_num_msb_led == $past(i_card_num[2]);
   endproperty
   a_msb_top: assert property (p_msb_top) // R03
      else $error("top LED is not the MSB");
   property p_lock_led;
      @(posedge i_mclk) disable iff (!i_rstn)
         $rose(lock_lvl) |=> o_bit_lock_led;
   endproperty
   a_lock_led: assert property (p_lock_led) // R01
      else $error("lock LED not lit after lock");
   property p_lock_code;
      @(posedge i_mclk) disable iff (!i_rstn)
         o_status.bit_lock_code == o_bit_lock_led;
   endproperty
   a_lock_code: assert property (p_lock_code) // R05
      else $error("lock code disagrees with lock LED");
   property p_cfg_led;
      @(posedge i_mclk) disable iff (!i_rstn)
         i_cfg_done |=> o_cfg_led;
   endproperty
   a_cfg_led: assert property (p_cfg_led) // R04
      else $error("config LED not lit");
   property p_frame_lock;
      @(posedge i_mclk) disable iff (!i_rstn)
         i_frame_sync_state == csi_pkg::CSI_LOCK
            |=> o_status.frame_sync_state_code == 2'h2;
   endproperty
   a_frame_lock: assert property (p_frame_lock) // R06
      else $error("frame lock code not 2");
   property p_sf_off;
      @(posedge i_mclk) disable iff (!i_rstn)
         !i_subframe_sync_en |=> !o_status.sf_valid
            && o_status.subframe_sync_state_code == 2'h0;
   endproperty
   a_sf_off: assert property (p_sf_off) // R07
      else $error("subframe status given while unconfigured");
   property p_sfc_off;
      @(posedge i_mclk) disable iff (!i_rstn)
         !i_subframe_sync_en |=> o_subframe_counter_value == '0;
   endproperty
   a_sfc_off: assert property (p_sfc_off) // R08
      else $error("subframe count given while unconfigured");
   property p_time_code;
      @(posedge i_mclk) disable iff (!i_rstn)
         !i_time_locked && i_time_flywheel
            |=> o_status.time_reader_state_code == 2'h1;
   endproperty
   a_time_code: assert property (p_time_code) // R09
      else $error("time code not 1 for flywheel unlock");
   // Pin held steady for six edges: three stages, filter, output reg
   sequence s_pin_held_high;
      i_bit_dpll_locked [*6];
   endsequence
   sequence s_pin_held_low;
      !i_bit_dpll_locked [*6];
   endsequence
   property p_lock_on;
      @(posedge i_mclk) disable iff (!i_rstn)
         s_pin_held_high |-> o_bit_lock_led;
   endproperty
   a_lock_on: assert property (p_lock_on) // R01
      else $error("lock LED dark after steady lock");
   property p_lock_off;
      @(posedge i_mclk) disable iff (!i_rstn)
         s_pin_held_low |-> !o_bit_lock_led;
   endproperty
   a_lock_off: assert property (p_lock_off) // R01
      else $error("lock LED lit without lock");
   property p_cfg_off;
      @(posedge i_mclk) disable iff (!i_rstn)
         !i_cfg_done |=> !o_cfg_led;
   endproperty
   a_cfg_off: assert property (p_cfg_off) // R04
      else $error("config LED lit before configuration");
   property p_frame_check;
      @(posedge i_mclk) disable iff (!i_rstn)
         i_frame_sync_state == csi_pkg::CSI_CHECK
            |=> o_status.frame_sync_state_code == `CSI_FS_CHECK;
   endproperty
   a_frame_check: assert property (p_frame_check) // R06
      else $error("frame check code not 1");
   property p_frame_search;
      @(posedge i_mclk) disable iff (!i_rstn)
         i_frame_sync_state == csi_pkg::CSI_SEARCH
            |=> o_status.frame_sync_state_code == `CSI_FS_SEARCH;
   endproperty
   a_frame_search: assert property (p_frame_search) // R06
      else $error("frame search code not 0");
   property p_sf_lock;
      @(posedge i_mclk) disable iff (!i_rstn)
         i_subframe_sync_en && i_subframe_sync_state == csi_pkg::CSI_LOCK
            |=> o_status.sf_valid
               && o_status.subframe_sync_state_code == `CSI_FS_LOCK;
   endproperty
   a_sf_lock: assert property (p_sf_lock) // R07
      else $error("subframe lock code not 2");
   property p_sfc_on;
      @(posedge i_mclk) disable iff (!i_rstn)
         i_subframe_sync_en
            |=> o_subframe_counter_value == $past(i_subframe_count);
   endproperty
   a_sfc_on: assert property (p_sfc_on) // R08
      else $error("subframe count not passed to host");
   property p_time_lock;
      @(posedge i_mclk) disable iff (!i_rstn)
         i_time_locked |=> o_status.time_reader_state_code
            == `CSI_TC_LOCK_FLY;
   endproperty
   a_time_lock: assert property (p_time_lock) // R09
      else $error("time code not 3 for reader lock");
   property p_time_nofly;
      @(posedge i_mclk) disable iff (!i_rstn)
         !i_time_locked && !i_time_flywheel
            |=> o_status.time_reader_state_code == `CSI_TC_UNLOCK_NOFLY;
   endproperty
   a_time_nofly: assert property (p_time_nofly) // R09
      else $error("time code not 0 without flywheel");
endmodule

// file: verilog/csi_defs.svh
// Constants for the card status indicator block
`ifndef CSI_DEFS_SVH
`define CSI_DEFS_SVH
`define CSI_CARD_NUM_RST    3'h0
`define CSI_BIT_LOCKED      1'h1
`define CSI_BIT_UNLOCKED    1'h0
`define CSI_FS_LOCK         2'h2
`define CSI_FS_CHECK        2'h1
`define CSI_FS_SEARCH       2'h0
`define CSI_TC_LOCK_FLY     2'h3
`define CSI_TC_UNLOCK_FLY   2'h1
`define CSI_TC_UNLOCK_NOFLY 2'h0
`define CSI_SYNC_STAGES     3
`endif

// file: verilog/csi_pkg.sv
// Types for the card status indicator block
package csi_pkg;
   typedef enum logic [1:0] {
      CSI_SEARCH,
      CSI_CHECK,
      CSI_LOCK
   } csi_sync_e;
   typedef struct packed {
      logic card_num_msb_led;
      logic card_num_mid_led;
      logic card_num_lsb_led;
   } csi_card_leds_s;
   typedef struct packed {
      logic       sf_valid;
      logic [1:0] subframe_sync_state_code;
      logic [1:0] frame_sync_state_code;
      logic [1:0] time_reader_state_code;
      logic       bit_lock_code;
   } csi_status_s;
endpackage

// file: verilog/csi_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
`include "csi_defs.svh"
module csi_pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rstn,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [WIDTH-1:0] lvl_d;
   // Refuse an empty vector while the design is elaborated
   if (WIDTH < 1) begin : g_bad_width
      $error("csi_pin_sync: WIDTH must be at least 1");
   end
   // --------------------------------------------------
   // Level follows only when the second and third agree
   // --------------------------------------------------
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end
   // First stage feeds only the second, to hold metastability back
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_q <= '0;
      end else begin
         s1_q  <= i_async;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end
   assign o_level = lvl_q;
endmodule

// file: verification/csi_panel_model.sv
// Rear-panel reader: turns the card LEDs back into a card number
`timescale 1ns/10ps
module csi_panel_model (
   input  wire csi_pkg::csi_card_leds_s i_card_leds,
   input  wire logic                    i_bit_lock_led,
   input  wire logic                    i_cfg_led,
   output logic [2:0]                   o_card_id,
   output logic                         o_left_led,
   output logic                         o_right_led
);
   // ------------------------------------------------------------
   // Panel view
   // ------------------------------------------------------------
   // Top LED weighs most; lit reads as one, dark as zero
   assign o_card_id = {i_card_leds.card_num_msb_led,
                       i_card_leds.card_num_mid_led,
                       i_card_leds.card_num_lsb_led};
   // Lower pair: left is loop lock, right is configuration
   assign o_left_led  = i_bit_lock_led;
   assign o_right_led = i_cfg_led;
endmodule

// file: verification/card_status_indicator_test.sv
// Self-checking bench for the card status indicator block
`timescale 1ns/10ps
module card_status_indicator_test;
   logic i_mclk = 1'b0, i_rstn = 1'b0, lock = 1'b0, cfg = 1'b0;
   logic we = 1'b0, tl = 1'b0, tf = 1'b0, sfen = 1'b0, e_cfg, v;
   logic [2:0] num = 3'h0, held = 3'h0, seen;
   logic [9:0] cnt = 10'h000, sfc;
   logic [7:0] e_st;
   logic [31:0] seed = 32'h3342, r;
   csi_pkg::csi_sync_e fs = csi_pkg::CSI_SEARCH, ss = csi_pkg::CSI_SEARCH;
   csi_pkg::csi_card_leds_s leds;
   csi_pkg::csi_status_s st;
   logic lled, cled, left, right;
   int fails = 0, checked = 0, cyc = 0;

   csi_top dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_bit_dpll_locked(lock),
      .i_cfg_done(cfg), .i_card_num_we(we), .i_card_num(num),
      .i_frame_sync_state(fs), .i_subframe_sync_state(ss),
      .i_subframe_sync_en(sfen), .i_subframe_count(cnt),
      .i_time_locked(tl), .i_time_flywheel(tf), .o_card_leds(leds),
      .o_bit_lock_led(lled), .o_cfg_led(cled), .o_status(st),
      .o_subframe_counter_value(sfc));
   csi_panel_model panel (.i_card_leds(leds), .i_bit_lock_led(lled),
      .i_cfg_led(cled), .o_card_id(seen), .o_left_led(left),
      .o_right_led(right));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Repeatable stream so a failing run can be replayed exactly
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected status byte; locked without flywheel still reads three
   function logic [7:0] exp_st(input logic b);
      logic [1:0] t;
      t = tl ? 2'h3 : (tf ? 2'h1 : 2'h0);
      return {sfen, sfen ? 2'(ss) : 2'h0, 2'(fs), t, b};
   endfunction
   task chk_vec(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task chk_bit(input logic g, input logic e);
      chk_vec({15'h0000, g}, {15'h0000, e});
   endtask
   task results();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Clock and hang guard
   // ------------------------------------------------------------
   initial begin
      forever #4 i_mclk = ~i_mclk;
   end
   // Whole run needs about 104 cycles; the ceiling leaves wide margin
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         results();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(negedge i_mclk);
      chk_vec({3'h0, leds, lled, cled, st}, 16'h0000);
      i_rstn = 1'b1;
      $display("reset test done");
      // Lock rises, falls, rises: old value for 3 edges, new by 6
      for (int k = 0; k < 3; k++) begin
         v = (k != 1);
         lock = v;
         repeat (3) @(negedge i_mclk);
         chk_bit(lled, !v);
         repeat (3) @(negedge i_mclk);
         chk_bit(lled, v);
         chk_bit(left, v);
         chk_bit(st.bit_lock_code, v);
      end
      $display("lock test done");
      // First eight writes walk every card number back to back
      for (int i = 0; i < 60; i++) begin
         r = xs();
         we = (i < 8) ? 1'b1 : r[0];
         num = (i < 8) ? 3'(i) : r[3:1];
         cfg = r[4];
         tl = r[5];
         tf = r[6];
         sfen = r[7];
         fs = csi_pkg::csi_sync_e'(r[9:8] % 2'h3);
         ss = csi_pkg::csi_sync_e'(r[11:10] % 2'h3);
         cnt = r[21:12];
         if (we) begin
            held = num;
         end
         e_cfg = cfg;
         e_st = exp_st(1'b1);
         @(negedge i_mclk);
         chk_vec({13'h0000, leds}, {13'h0000, held});
         chk_vec({13'h0000, seen}, {13'h0000, held});
         chk_bit(right, e_cfg);
         chk_vec({8'h00, st}, {8'h00, e_st});
         chk_vec({6'h00, sfc}, {6'h00, e_st[7] ? cnt : 10'h000});
      end
      we = 1'b0;
      $display("random status test done");
      // Mid-run reset clears every output; lock must be relearned
      i_rstn = 1'h0;
      repeat (2) @(negedge i_mclk);
      chk_vec({3'h0, leds, lled, cled, st}, 16'h0000);
      i_rstn = 1'h1;
      repeat (3) @(negedge i_mclk);
      chk_bit(lled, 1'h0);
      repeat (3) @(negedge i_mclk);
      chk_bit(lled, 1'h1);
      chk_vec({13'h0000, leds}, 16'h0000);
      // One write after the reset shows on the next edge, then holds
      we = 1'h1;
      num = 3'h5;
      @(negedge i_mclk);
      we = 1'h0;
      chk_vec({13'h0000, seen}, 16'h0005);
      @(negedge i_mclk);
      chk_vec({13'h0000, leds}, 16'h0005);
      $display("mid-run reset test done");
      results();
   end
endmodule
